// ==== rtl/acs_converter.sv ====
// Converter end: conversion start, completion actions, formatting and sleep
// Function
// - Done flag set at every conversion end
// - Done flag held until software clears it
// - Completion in sleep with irq enable wakes
// - Sleep conversion only on internal RC clock
// - Result left or right justified by select
// - Result writes stored right justified
// - Start by go, trigger or continuous retrigger
// - Software avoids go with first enable write
// - Old result copied to previous when select zero
// - Completion clears go unless continuous, sets flags, updates accumulator
// - Setpoint error every one or two conversions
// - RC clock delays start one instruction cycle
// - Sleep completion without irq turns converter off
// - Sleep trigger on RC clock converts
// - Sleep trigger on other clock waits pending
// - Trigger rising edge sets go bit
// - Trigger user guarantees acquisition timing
// - Zero acquisition time means software waits
// - Software polls go or waits interrupt
// - Control 0x94 enables, right justifies, RC clock
// - Clock select one means internal RC
`timescale 1ns/100ps
`default_nettype none
module acs_converter #(
    parameter int CONV_CYCLES = acs_pkg::CONV_CYCLES
) (
    input  wire logic                     CLOCK,
    input  wire logic                     RST,
    input  wire logic                     CE,
    input  wire logic [acs_pkg::RES_W-1:0] SAMPLE,
    acs_link_if.dev                       LINK
);
    typedef logic [acs_pkg::PAIR_W-1:0] pair_t;

    // Place a 12-bit value in the pair per justify select
    function automatic pair_t justify(input logic [acs_pkg::RES_W-1:0] v, input logic fm);
        pair_t r;
        r = {{acs_pkg::JUST_PAD{1'b0}}, v};
        if (!fm) begin
            r = {v, {acs_pkg::JUST_PAD{1'b0}}};
        end
        return r;
    endfunction

    acs_pkg::acs_state_t     state_reg, state_next;
    logic [7:0]              ctl_reg, ctl_next;
    logic [acs_pkg::RES_W-1:0] res_reg, res_next, prev_reg, prev_next, first_reg, first_next;
    logic [acs_pkg::ACC_W-1:0] acc_reg, acc_next;
    logic [7:0]              cnt_reg, cnt_next;
    logic                    done_reg, done_next, thr_reg, thr_next, math_reg, math_next;
    logic                    pend_reg, pend_next, half_reg, half_next, off_reg, off_next;
    logic                    wake_reg, wake_next;
    logic [acs_pkg::TRIG_W-1:0] trig_idx;
    logic                    trig_prev_reg, trig_prev_next, trig_now, trig_rise;
    logic                    on, cs, fm, continuous_enable, go;
    logic [acs_pkg::RES_W:0] err;

    assign on   = ctl_reg[acs_pkg::CTL_ON];
    assign cs   = ctl_reg[acs_pkg::CTL_CS];     // 1 selects internal RC clock
    assign fm   = ctl_reg[acs_pkg::CTL_FM];
    assign continuous_enable = ctl_reg[acs_pkg::CTL_CONTINUOUS_ENABLE];
    assign go   = ctl_reg[acs_pkg::CTL_GO];
    assign trig_idx  = LINK.trig_sel;
    assign trig_now  = LINK.trig_src[trig_idx];
    assign trig_rise = trig_now && !trig_prev_reg;
    // Setpoint error of the incoming sample; a negative step wraps high and trips the test
    assign err = {1'b0, SAMPLE} - {1'b0, (LINK.double_sample_enable ? first_reg : acs_pkg::RES_W'(0))};

    // Next-state logic for control, sequencing and completion actions
    always_comb begin
        state_next = state_reg;
        ctl_next = ctl_reg;
        res_next = res_reg;
        prev_next = prev_reg;
        first_next = first_reg;
        acc_next = acc_reg;
        cnt_next = cnt_reg;
        done_next = done_reg;
        thr_next = thr_reg;
        math_next = math_reg;
        pend_next = pend_reg;
        half_next = half_reg;
        off_next = off_reg;
        wake_next = 1'b0;
        trig_prev_next = trig_now;
        if (LINK.ctl_we) begin
            ctl_next = LINK.ctl_wdata;  // 0x94: on, right justify, RC clock
            off_next = 1'b0;
        end
        if (LINK.res_we) begin
            res_next = LINK.res_wdata[acs_pkg::RES_W-1:0];  // Stored right justified
        end
        if (LINK.flag_clear) done_next = 1'b0;   // Only software clears it
        if (LINK.tflag_clear) thr_next = 1'b0;
        if (LINK.math_clear) math_next = 1'b0;
        if (!LINK.sleeping) off_next = 1'b0;
        // A trigger edge sets go; in sleep off RC it is held pending
        if (on && trig_rise) begin
            if (LINK.sleeping && !cs) begin
                pend_next = 1'b1;
            end else begin
                ctl_next[acs_pkg::CTL_GO] = 1'b1;
            end
        end
        if (pend_reg && !LINK.sleeping) begin
            pend_next = 1'b0;
            ctl_next[acs_pkg::CTL_GO] = 1'b1;
        end
        case (state_reg)
            acs_pkg::ACS_IDLE: begin
                // Sleep runs only on the RC clock; converter off stays off
                if (on && go && !off_reg && (!LINK.sleeping || cs)) begin
                    cnt_next = '0;
                    state_next = cs ? acs_pkg::ACS_DELAY : acs_pkg::ACS_CONV;
                end
            end
            acs_pkg::ACS_DELAY: begin
                cnt_next = cnt_reg + 8'h01;
                if (cnt_reg == 8'(acs_pkg::RC_DELAY - 1)) begin
                    cnt_next = '0;
                    state_next = acs_pkg::ACS_CONV;
                end
            end
            acs_pkg::ACS_CONV: begin
                cnt_next = cnt_reg + 8'h01;
                if (!on) begin
                    state_next = acs_pkg::ACS_IDLE;
                end else if (cnt_reg == 8'(CONV_CYCLES - 1)) begin
                    cnt_next = '0;
                    if (!LINK.previous_source_select) prev_next = res_reg;
                    res_next = SAMPLE;
                    done_next = 1'b1;
                    math_next = 1'b1;
                    acc_next = acc_reg + acs_pkg::ACC_W'(SAMPLE);
                    // Continuous mode keeps go set and retriggers
                    if (!continuous_enable) ctl_next[acs_pkg::CTL_GO] = 1'b0;
                    state_next = continuous_enable ? acs_pkg::ACS_CONV : acs_pkg::ACS_IDLE;
                    // Error on every, or every second, conversion
                    half_next = LINK.double_sample_enable ? !half_reg : 1'b0;
                    first_next = SAMPLE;
                    if (!LINK.double_sample_enable || half_reg) begin
                        if ({3'h0, err} >= LINK.threshold)
                            thr_next = 1'b1;
                    end
                    if (LINK.sleeping) begin
                        if (LINK.irq_enable) wake_next = 1'b1;
                        else begin
                            off_next = 1'b1;                  // On bit stays set
                            state_next = acs_pkg::ACS_IDLE;
                        end
                    end
                end
            end
            default: state_next = acs_pkg::ACS_IDLE;
        endcase
    end

    // Registers, frozen while clock enable is low
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state_reg <= acs_pkg::ACS_IDLE;
            ctl_reg <= acs_pkg::CTL_RESET;
            res_reg <= '0;
            prev_reg <= '0;
            first_reg <= '0;
            acc_reg <= '0;
            cnt_reg <= '0;
            done_reg <= 1'b0;
            thr_reg <= 1'b0;
            math_reg <= 1'b0;
            pend_reg <= 1'b0;
            half_reg <= 1'b0;
            off_reg <= 1'b0;
            wake_reg <= 1'b0;
            trig_prev_reg <= 1'b0;
        end else if (CE) begin
            state_reg <= state_next;
            ctl_reg <= ctl_next;
            res_reg <= res_next;
            prev_reg <= prev_next;
            first_reg <= first_next;
            acc_reg <= acc_next;
            cnt_reg <= cnt_next;
            done_reg <= done_next;
            thr_reg <= thr_next;
            math_reg <= math_next;
            pend_reg <= pend_next;
            half_reg <= half_next;
            off_reg <= off_next;
            wake_reg <= wake_next;
            trig_prev_reg <= trig_prev_next;
        end
    end

    // Readback views of the stored state
    assign LINK.ctl_rdata   = ctl_reg;
    assign LINK.res_rdata   = justify(res_reg, fm);
    assign LINK.prev_rdata  = justify(prev_reg, fm);
    assign LINK.done_flag   = done_reg;
    assign LINK.thr_flag    = thr_reg;
    assign LINK.math_flag   = math_reg;
    assign LINK.acc         = acc_reg;
    assign LINK.wake        = wake_reg;
    assign LINK.conv_active = (state_reg != acs_pkg::ACS_IDLE);
endmodule
`default_nettype wire

// ==== rtl/acs_pkg.sv ====
// Package: shared constants and types for the conversion sequencer ends
package acs_pkg;
    localparam int RES_W       = 12;                     // Result width
    localparam int PAIR_W      = 16;                     // Result register pair width
    localparam int JUST_PAD    = PAIR_W - RES_W;         // Left-justify shift
    localparam int ACC_W       = 18;                     // Accumulator width
    localparam int TRIG_W      = 4;                      // Trigger select width
    localparam int CONV_CYCLES = 16;                     // Clocks per conversion
    localparam int RC_DELAY    = 4;                      // One instruction cycle of delay
    // Main control byte layout
    localparam int CTL_ON      = 7;
    localparam int CTL_CONTINUOUS_ENABLE    = 6;
    localparam int CTL_CS      = 4;
    localparam int CTL_FM      = 2;
    localparam int CTL_GO      = 0;
    localparam logic [7:0] CTL_RESET = 8'h00;
    typedef enum logic [1:0] {ACS_IDLE, ACS_DELAY, ACS_CONV} acs_state_t;
endpackage

// ==== rtl/acs_link_if.sv ====
// Interface: joins the converter end and the controlling end
`timescale 1ns/100ps
`default_nettype none
interface acs_link_if;
    logic [7:0]  ctl_wdata;   // Main control write data
    logic        ctl_we;      // Main control write strobe
    logic [7:0]  ctl_rdata;   // Main control readback
    logic [15:0] res_wdata;   // Result pair write data
    logic        res_we;      // Result pair write strobe
    logic [15:0] res_rdata;   // Formatted result pair
    logic [15:0] prev_rdata;  // Previous result
    logic        previous_source_select;        // Previous source select
    logic        double_sample_enable;        // Double sample enable
    logic [15:0] threshold;   // Threshold compare value
    logic [3:0]  trig_sel;    // Trigger select field
    logic [15:0] trig_src;    // Trigger source lines
    logic        irq_enable;  // Conversion interrupt enable
    logic        flag_clear;  // Done flag clear strobe
    logic        tflag_clear; // Threshold flag clear strobe
    logic        math_clear;  // Math-ready clear strobe
    logic        sleeping;    // Core is asleep
    logic        done_flag;   // Conversion done flag
    logic        thr_flag;    // Threshold flag
    logic        math_flag;   // Math ready flag
    logic [17:0] acc;         // Accumulator
    logic        wake;        // Wake request pulse
    logic        conv_active; // Converter busy
    modport dev (input ctl_wdata, ctl_we, res_wdata, res_we, previous_source_select, double_sample_enable, threshold,
                 trig_sel, trig_src, irq_enable, flag_clear, tflag_clear, math_clear,
                 sleeping,
                 output ctl_rdata, res_rdata, prev_rdata, done_flag, thr_flag, math_flag,
                 acc, wake, conv_active);
    modport host (output ctl_wdata, ctl_we, res_wdata, res_we, previous_source_select, double_sample_enable, threshold,
                  trig_sel, trig_src, irq_enable, flag_clear, tflag_clear, math_clear,
                  sleeping,
                  input ctl_rdata, res_rdata, prev_rdata, done_flag, thr_flag, math_flag,
                  acc, wake, conv_active);
endinterface
`default_nettype wire

// ==== rtl/acs_controller.sv ====
// Controlling end: software-side strobes and trigger lines onto the link
`timescale 1ns/100ps
`default_nettype none
module acs_controller (
    input  wire logic        CLOCK,
    input  wire logic        RST,
    input  wire logic        CE,
    input  wire logic [7:0]  CTL_WDATA,
    input  wire logic        CTL_WE,
    input  wire logic [15:0] RES_WDATA,
    input  wire logic        RES_WE,
    input  wire logic        PREVIOUS_SOURCE_SELECT_SEL,
    input  wire logic        DOUBLE_SAMPLE_ENABLE_SEL,
    input  wire logic [15:0] THRESHOLD,
    input  wire logic [3:0]  TRIG_SEL,
    input  wire logic [15:0] TRIG_SRC,
    input  wire logic        IRQ_ENABLE,
    input  wire logic        FLAG_CLEAR,
    input  wire logic        TFLAG_CLEAR,
    input  wire logic        MATH_CLEAR,
    input  wire logic        SLEEP_REQ,
    input  wire logic        GLOBAL_IRQ_ENABLE,
    output logic             SLEEPING,
    output logic             RUN_ISR,
    output logic [15:0]      RESULT,
    output logic             BUSY,
    acs_link_if.host         LINK
);
    logic sleep_reg, sleep_next, isr_reg, isr_next;
    logic done_prev_reg, done_prev_next;
    logic [15:0] result_reg, result_next;

    // Sleep state and wake handling; ISR only when global enable set
    always_comb begin
        sleep_next = sleep_reg;
        isr_next = 1'b0;
        result_next = result_reg;
        done_prev_next = LINK.done_flag;
        if (SLEEP_REQ) sleep_next = 1'b1;
        if (LINK.wake) begin
            sleep_next = 1'b0;
            isr_next = GLOBAL_IRQ_ENABLE;
        end else if (!sleep_reg && LINK.done_flag && !done_prev_reg && IRQ_ENABLE &&
                     GLOBAL_IRQ_ENABLE) begin
            // Entered once per flag rise, so a slow clear does not re-enter the routine
            isr_next = 1'b1;
        end
        if (!LINK.conv_active) result_next = LINK.res_rdata;  // Read after done
    end

    always_ff @(posedge CLOCK) begin
        if (RST) begin
            sleep_reg <= 1'b0;
            isr_reg <= 1'b0;
            result_reg <= '0;
            done_prev_reg <= 1'b0;
        end else if (CE) begin
            done_prev_reg <= done_prev_next;
            sleep_reg <= sleep_next;
            isr_reg <= isr_next;
            result_reg <= result_next;
        end
    end

    // Pass-through of software strobes; user keeps go out of first enable write
    assign LINK.ctl_wdata   = CTL_WDATA;
    assign LINK.ctl_we      = CTL_WE && CE;
    assign LINK.res_wdata   = RES_WDATA;
    assign LINK.res_we      = RES_WE && CE;
    assign LINK.previous_source_select        = PREVIOUS_SOURCE_SELECT_SEL;
    assign LINK.double_sample_enable        = DOUBLE_SAMPLE_ENABLE_SEL;
    assign LINK.threshold   = THRESHOLD;
    assign LINK.trig_sel    = TRIG_SEL;
    assign LINK.trig_src    = TRIG_SRC;   // Timing left to trigger user
    assign LINK.irq_enable  = IRQ_ENABLE;
    assign LINK.flag_clear  = FLAG_CLEAR && CE;
    assign LINK.tflag_clear = TFLAG_CLEAR && CE;
    assign LINK.math_clear  = MATH_CLEAR && CE;
    assign LINK.sleeping    = sleep_reg;
    assign SLEEPING = sleep_reg;
    assign RUN_ISR  = isr_reg;
    assign RESULT   = result_reg;
    assign BUSY     = LINK.ctl_rdata[acs_pkg::CTL_GO];    // Poll go for done
endmodule
`default_nettype wire

// ==== bench/acs_link_sva.sv ====
// Checker: link-level timing relations between the two sequencer ends
`timescale 1ns/100ps
`default_nettype none
module acs_link_sva #(
    parameter int CONV_CYCLES = acs_pkg::CONV_CYCLES
) (
    input wire logic        CLOCK,
    input wire logic        RST,
    input wire logic [7:0]  ctl_rdata,
    input wire logic [15:0] res_rdata,
    input wire logic [15:0] prev_rdata,
    input wire logic        previous_source_select,
    input wire logic [3:0]  trig_sel,
    input wire logic [15:0] trig_src,
    input wire logic        irq_enable,
    input wire logic        flag_clear,
    input wire logic        sleeping,
    input wire logic        done_flag,
    input wire logic        math_flag,
    input wire logic        wake,
    input wire logic        conv_active
);
    // Control bits decoded once for readability
    wire logic go = ctl_rdata[acs_pkg::CTL_GO];
    wire logic rc = ctl_rdata[acs_pkg::CTL_CS];
    wire logic fm = ctl_rdata[acs_pkg::CTL_FM];
    wire logic on = ctl_rdata[acs_pkg::CTL_ON];
    localparam int RC_LEN = acs_pkg::RC_DELAY + CONV_CYCLES;
    // Length of the current busy stretch; the RC start delay shows up as extra cycles
    int run_len;
    always_ff @(posedge CLOCK) begin
        if (RST || !conv_active) begin
            run_len <= 0;
        end else begin
            run_len <= run_len + 1;
        end
    end
    default clocking cb @(posedge CLOCK);
    endclocking
    default disable iff (RST);
    // End of conversion; aborts are never issued by the bench, so a fall means completion
    sequence s_done;
        $fell(conv_active);
    endsequence
    // RC-clocked conversion finished; its busy stretch includes the start delay
    sequence s_rc_done;
        s_done ##0 rc;
    endsequence
    AST_DONE_SET: assert property (s_done |-> done_flag && math_flag)
        else $error("flags not set at conversion end");
    AST_DONE_HOLD: assert property (done_flag && !flag_clear |=> done_flag)
        else $error("done flag dropped without a clear");
    AST_GO_CLEAR: assert property (s_done |-> ctl_rdata[acs_pkg::CTL_CONTINUOUS_ENABLE] || !go)
        else $error("go bit still set after single conversion");
    AST_PREV_COPY: assert property (s_done ##0 (!previous_source_select && fm) |-> prev_rdata == $past(res_rdata))
        else $error("previous result not copied from old result");
    AST_JUSTIFY: assert property (fm ? res_rdata[15:12] == 4'h0 : res_rdata[3:0] == 4'h0)
        else $error("padding bits of result pair not zero");
    AST_WAKE: assert property (s_done ##0 (sleeping && irq_enable) |-> ##[0:2] wake)
        else $error("no wake after conversion in sleep");
    AST_NO_WAKE: assert property (wake |-> irq_enable)
        else $error("wake with conversion interrupt disabled");
    AST_RC_DELAY: assert property (s_rc_done |-> run_len == RC_LEN)
        else $error("RC clock start not delayed as expected");
    AST_CONV_LEN: assert property (s_done ##0 !rc |-> run_len == CONV_CYCLES)
        else $error("conversion length wrong on system clock");
    AST_START: assert property ($rose(go) && !rc && on && !sleeping |-> ##[0:1] conv_active)
        else $error("conversion did not start after go");
    AST_TRIG: assert property ($rose(trig_src[trig_sel]) && on && !go && !conv_active && !sleeping
        |-> ##[1:2] go)
        else $error("trigger edge did not set go");
endmodule
`default_nettype wire

// ==== bench/adc_conversion_sequencer_bench.sv ====
// Bench: both ends joined on the link, checked against a behavioural model
`timescale 1ns/100ps
`default_nettype none
module adc_conversion_sequencer_bench;
    logic        clock = 1'b0, rst = 1'b1, ctl_we = 1'b0, res_we = 1'b0;
    logic        irq_en = 1'b0, global_irq_enable = 1'b0, slp_req = 1'b0, sleeping, run_isr, busy;
    logic [7:0]  ctl_wdata = 8'h00;
    logic [15:0] res_wdata = 16'h0000, trig_src = 16'h0000, result;
    logic [11:0] sample = 12'h000;
    logic [3:0]  trig_sel = 4'h3;
    logic [2:0]  clr = 3'h0;    // Done, threshold and math clear strobes
    logic        previous_source_select = 1'b0;   // Previous source select
    localparam int CONV_N = 4;  // Short conversions keep the run brief
    int          errors = 0, check_count = 0, cyc = 0, isr_cnt = 0;
    int          exp_res = 0, exp_prev = 0, exp_acc = 0;
    acs_link_if link ();
    always #5 clock = ~clock;
    // Short conversions keep the run brief; expectations do not depend on the length
    acs_converter #(.CONV_CYCLES(CONV_N)) acs_converter_inst (.CLOCK(clock), .RST(rst), .CE(1'b1),
        .SAMPLE(sample), .LINK(link.dev));
    acs_controller acs_controller_inst (.CLOCK(clock), .RST(rst), .CE(1'b1),
        .CTL_WDATA(ctl_wdata), .CTL_WE(ctl_we), .RES_WDATA(res_wdata), .RES_WE(res_we),
        .PREVIOUS_SOURCE_SELECT_SEL(previous_source_select), .DOUBLE_SAMPLE_ENABLE_SEL(1'b0), .THRESHOLD(16'h0800), .TRIG_SEL(trig_sel),
        .TRIG_SRC(trig_src), .IRQ_ENABLE(irq_en), .FLAG_CLEAR(clr[0]), .TFLAG_CLEAR(clr[1]),
        .MATH_CLEAR(clr[2]), .SLEEP_REQ(slp_req), .GLOBAL_IRQ_ENABLE(global_irq_enable),
        .SLEEPING(sleeping), .RUN_ISR(run_isr), .RESULT(result), .BUSY(busy), .LINK(link.host));
    acs_link_sva #(.CONV_CYCLES(CONV_N)) acs_link_sva_inst (.CLOCK(clock), .RST(rst),
        .ctl_rdata(link.ctl_rdata),
        .res_rdata(link.res_rdata), .prev_rdata(link.prev_rdata), .previous_source_select(link.previous_source_select),
        .trig_sel(link.trig_sel), .trig_src(link.trig_src), .irq_enable(link.irq_enable),
        .flag_clear(link.flag_clear), .sleeping(link.sleeping), .done_flag(link.done_flag),
        .math_flag(link.math_flag), .wake(link.wake), .conv_active(link.conv_active));
    task automatic chk(input string what, input logic [17:0] seen, input logic [17:0] exp);
        check_count++;
        if (seen !== exp) begin
            errors++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic summarize;
        $display("Checks %0d mismatches %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Cycle ceiling cuts a hang short; also counts service routine entries
    always @(posedge clock) begin
        cyc++;
        if (run_isr === 1'b1)
            isr_cnt++;
        if (cyc == 20000) begin
            errors++;
            summarize();
        end
    end
    task automatic wr_ctl(input logic [7:0] v);
        @(posedge clock) #1;
        ctl_wdata = v;
        ctl_we = 1'b1;
        @(posedge clock) #1;
        ctl_we = 1'b0;
        @(posedge clock) #1;
    endtask
    // One conversion: how 0 software go, 1 trigger, 2 trigger while asleep
    task automatic conv(input logic [11:0] s, input logic [7:0] base, input int how);
        int n;
        logic [15:0] f;
        n = 0;
        f = base[2] ? {4'h0, s} : {s, 4'h0};
        sample = s;
        clr = 3'h7;
        @(posedge clock) #1;
        clr = 3'h0;
        wr_ctl(base);                               // Enable first, go in a later write
        if (how == 0)
            wr_ctl(base | 8'h01);                   // Acquisition wait is software's
        if (how == 2) begin
            slp_req = 1'b1;
            @(posedge clock) #1;
            slp_req = 1'b0;
            @(posedge clock) #1;
        end
        if (how > 0) begin
            trig_src[trig_sel] = 1'b1;              // Spaced past acquisition
            @(posedge clock) #1;
            trig_src = 16'h0000;
        end
        while (link.done_flag !== 1'b1 && n < 200) begin
            @(posedge clock) #1;
            n++;
        end
        repeat (4) @(posedge clock) #1;
        if (!previous_source_select)
            exp_prev = exp_res;
        exp_res = s;
        exp_acc = (exp_acc + s) % 262144;
        chk("done", link.done_flag, 1'b1);
        chk("go", busy, 1'b0);
        chk("math", link.math_flag, 1'b1);
        chk("acc", link.acc, 18'(exp_acc));
        chk("thr", link.thr_flag, s >= 12'h800);
        chk("res", link.res_rdata, f);
        chk("result", result, f);
        if (base[2])
            chk("prev", link.prev_rdata, 18'(exp_prev));
        if (how == 2)
            chk("asleep", sleeping, !irq_en);
    endtask
    initial begin
        logic [11:0] v;
        int n;
        void'($urandom(32'h21ec229e));
        repeat (12) @(posedge clock);
        #1 rst = 1'b0;
        chk("ctl reset", link.ctl_rdata, 8'h00);
        chk("result reset", result, 16'h0000);
        wr_ctl(8'h94);
        chk("ctl", link.ctl_rdata, 8'h94);
        $display("Test control done");
        for (int i = 0; i < 8; i++) begin
            trig_sel = 4'($urandom);
            previous_source_select = 1'($urandom);
            conv(12'($urandom), 8'h80 | (i[1] ? 8'h10 : 8'h00) | (i[0] ? 8'h04 : 8'h00), i / 4);
        end
        $display("Test conversions done");
        previous_source_select = 1'b0;
        v = 12'($urandom);
        wr_ctl(8'h80);
        res_wdata = {4'h0, v};
        res_we = 1'b1;
        @(posedge clock) #1;
        res_we = 1'b0;
        repeat (2) @(posedge clock) #1;
        chk("written", link.res_rdata, {v, 4'h0});
        exp_res = v;
        clr = 3'h7;
        @(posedge clock) #1;
        clr = 3'h0;
        wr_ctl(8'h05);
        repeat (10) @(posedge clock) #1;
        chk("refused", link.done_flag, 1'b0);
        chk("idle", link.conv_active, 1'b0);
        $display("Test write and refusal done");
        irq_en = 1'b1;
        global_irq_enable = 1'b1;
        n = isr_cnt;
        conv(12'($urandom), 8'h94, 2);
        chk("isr run", 18'(isr_cnt - n), 18'h1);
        global_irq_enable = 1'b0;
        n = isr_cnt;
        conv(12'($urandom), 8'h94, 2);
        chk("isr skipped", 18'(isr_cnt - n), 18'h0);
        irq_en = 1'b0;
        conv(12'($urandom), 8'h94, 2);
        chk("on kept", link.ctl_rdata[7], 1'b1);
        $display("Test sleep done");
        rst = 1'b1;
        repeat (2) @(posedge clock) #1;
        rst = 1'b0;
        chk("ctl after reset", link.ctl_rdata, 8'h00);
        chk("sleep after reset", sleeping, 1'b0);
        $display("Test second reset done");
        summarize();
    end
endmodule
`default_nettype wire
